//--- design/lctpg_pkg.sv
// Shared types and constants for the line camera test pattern generator.
// Assumes a single 20 MHz pixel clock and a synchronous active high reset.
package lctpg_pkg;

	localparam int        PIX_W          = 12;
	localparam int        CNT_W          = 12;
	localparam int        PER_W          = 16;
	localparam logic [11:0] LINE_LAST    = 12'hFFF;
	localparam logic [11:0] PIX_FIRST    = 12'h000;
	localparam logic [7:0]  MOVE_RESET   = 8'h00;
	localparam logic [PER_W-1:0] FR_RESET = 16'h0000;
	localparam logic [11:0] GRAY_8       = 12'h07F;
	localparam logic [11:0] GRAY_10      = 12'h1FF;
	localparam logic [11:0] GRAY_12      = 12'h7FF;
	localparam logic [11:0] BLACK        = 12'h000;
	localparam logic [7:0]  GRAD_TOP     = 8'hFF;

	typedef enum logic [2:0] {
		LCTPG_MODE_VIDEO = 3'h0,
		LCTPG_MODE_FIXED = 3'h1,
		LCTPG_MODE_MOVE  = 3'h2,
		LCTPG_MODE_BLACK = 3'h3,
		LCTPG_MODE_GRAY  = 3'h4
	} lctpg_mode_t;

	typedef enum logic [1:0] {
		LCTPG_DEPTH_8  = 2'h0,
		LCTPG_DEPTH_10 = 2'h1,
		LCTPG_DEPTH_12 = 2'h2
	} lctpg_depth_t;

	typedef enum logic {
		LCTPG_ST_IDLE   = 1'b0,
		LCTPG_ST_ACTIVE = 1'b1
	} lctpg_state_t;

	typedef struct packed {
		logic             valid;
		logic [PIX_W-1:0] data;
	} lctpg_pix_t;

endpackage

//--- design/lctpg_top.sv
// Test pattern generator placed in front of the video output.
// Assumes control inputs and sensor video come from logic on i_clk; the line trigger is a pin.
`timescale 1ns/1ps
module lctpg_top
	import lctpg_pkg::*;
(
	// Clock and reset.
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// Control from the camera configuration logic.
	input  wire lctpg_mode_t      i_mode,
	input  wire lctpg_depth_t     i_depth,
	input  wire logic             i_free_run,
	input  wire logic [PER_W-1:0] i_line_period,
	// Line trigger pin from the frame grabber.
	input  wire logic             i_line_trigger_input,
	// Sensor video in normal operation.
	input  wire lctpg_pix_t       i_video,
	// Video output to the frame grabber.
	output lctpg_pix_t            o_pix
);

	logic             trig_meta_q;
	logic             trig_sync_q;
	logic             trig_prev_q;
	logic             trig_edge;
	logic [PER_W-1:0] fr_cnt_q;
	logic             fr_tick;
	logic             test_mode;
	logic             start;
	lctpg_state_t     state_q;
	logic [CNT_W-1:0] pix_cnt_q;
	logic [7:0]       move_q;
	logic [PIX_W-1:0] pat_value;
	lctpg_pix_t       pix_q;
	logic [12:0]      valid_run_q;

	// Maps a pixel position to the 8-bit fixed gradient value.
	function automatic logic [7:0] grad8(input logic [CNT_W-1:0] p);
		logic [8:0] q;
		q = p[8:0];
		if (!q[0]) begin
			grad8 = q[8:1];
		end else begin
			grad8 = GRAD_TOP - q[8:1];
		end
	endfunction

	// Widens an 8-bit value so zero and full scale land on the end codes.
	function automatic logic [PIX_W-1:0] scale(input logic [7:0] v, input lctpg_depth_t d);
		case (d)
			LCTPG_DEPTH_10: scale = {2'h0, v, v[7:6]};
			LCTPG_DEPTH_12: scale = {v, v[7:4]};
			default:        scale = {4'h0, v};
		endcase
	endfunction

	// The trigger pin passes two flip-flops before the edge detector.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			trig_meta_q <= i_line_trigger_input;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
		end
	end

	assign trig_edge = trig_sync_q & ~trig_prev_q;

	// Internal line control signal for free run.
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_free_run || fr_tick) begin
			fr_cnt_q <= FR_RESET;
		end else begin
			fr_cnt_q <= fr_cnt_q + 16'h0001;
		end
	end

	assign fr_tick   = i_free_run && (fr_cnt_q >= i_line_period);
	assign test_mode = (i_mode != LCTPG_MODE_VIDEO);
	// A line starts only on a trigger edge or a free run tick; one already running is not restarted.
	assign start     = test_mode && (state_q == LCTPG_ST_IDLE) &&
	                   (i_free_run ? fr_tick : trig_edge);

	// Line sequencer.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_q   <= LCTPG_ST_IDLE;
			pix_cnt_q <= PIX_FIRST;
		end else begin
			case (state_q)
				LCTPG_ST_IDLE: begin
					pix_cnt_q <= PIX_FIRST;
					if (start) begin
						state_q <= LCTPG_ST_ACTIVE;
					end
				end
				LCTPG_ST_ACTIVE: begin
					pix_cnt_q <= pix_cnt_q + 12'h001;
					if (pix_cnt_q == LINE_LAST) begin
						state_q   <= LCTPG_ST_IDLE;
						pix_cnt_q <= PIX_FIRST;
					end
				end
				default: begin
					state_q   <= LCTPG_ST_IDLE;
					pix_cnt_q <= PIX_FIRST;
				end
			endcase
		end
	end

	// Moving gradient offset advances once per line emitted in the moving gradient mode.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			move_q <= MOVE_RESET;
		end else if (state_q == LCTPG_ST_ACTIVE && pix_cnt_q == LINE_LAST && i_mode == LCTPG_MODE_MOVE) begin
			move_q <= move_q + 8'h01;
		end
	end

	// Pattern values depend only on position, mode, depth and the moving gradient offset, never on exposure.
	always_comb begin
		case (i_mode)
			LCTPG_MODE_FIXED: pat_value = scale(grad8(pix_cnt_q), i_depth);
			LCTPG_MODE_MOVE:  pat_value = scale(pix_cnt_q[7:0] + move_q, i_depth);
			LCTPG_MODE_BLACK: pat_value = BLACK;
			LCTPG_MODE_GRAY: begin
				case (i_depth)
					LCTPG_DEPTH_10: pat_value = GRAY_10;
					LCTPG_DEPTH_12: pat_value = GRAY_12;
					default:        pat_value = GRAY_8;
				endcase
			end
			default:          pat_value = BLACK;
		endcase
	end

	// Output register selects sensor video or the synthesized line.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pix_q <= '0;
		end else if (!test_mode) begin
			pix_q <= i_video;
		end else begin
			pix_q.valid <= (state_q == LCTPG_ST_ACTIVE);
			pix_q.data  <= (state_q == LCTPG_ST_ACTIVE) ? pat_value : BLACK;
		end
	end

	assign o_pix = pix_q;

	// Counts consecutive valid output pixels so the line length can be checked.
	always_ff @(posedge i_clk) begin
		if (i_reset || !pix_q.valid) begin
			valid_run_q <= 13'h0000;
		end else begin
			valid_run_q <= valid_run_q + 13'h0001;
		end
	end

	sequence seq_fixed8_at(logic [8:0] pos);
		state_q == LCTPG_ST_ACTIVE && i_mode == LCTPG_MODE_FIXED &&
		i_depth == LCTPG_DEPTH_8 && pix_cnt_q[8:0] == pos;
	endsequence

	sequence seq_line_open;
		state_q == LCTPG_ST_ACTIVE && pix_cnt_q == PIX_FIRST;
	endsequence

	sequence seq_fixed_at(lctpg_depth_t dep, logic [8:0] pos);
		state_q == LCTPG_ST_ACTIVE && i_mode == LCTPG_MODE_FIXED &&
		i_depth == dep && pix_cnt_q[8:0] == pos;
	endsequence

	sequence seq_active_in(lctpg_mode_t m, lctpg_depth_t dep);
		state_q == LCTPG_ST_ACTIVE && i_mode == m && i_depth == dep;
	endsequence

	AST_TRIG_STARTS_LINE: assert property (@(posedge i_clk) disable iff (i_reset)
		(test_mode && !i_free_run && trig_edge && state_q == LCTPG_ST_IDLE) |=> seq_line_open)
		else $error("Trigger edge did not start a line.");

	AST_NO_LINE_WITHOUT_CAUSE: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_q == LCTPG_ST_ACTIVE) |-> $past(start))
		else $error("Line started without trigger or tick.");

	AST_FREE_RUN_LINE: assert property (@(posedge i_clk) disable iff (i_reset)
		(test_mode && i_free_run && fr_tick && state_q == LCTPG_ST_IDLE) |=> seq_line_open ##1
		(state_q == LCTPG_ST_ACTIVE)[*8])
		else $error("Free run tick did not emit a line.");

	AST_ODD_RISES: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h004)) |=> o_pix.valid && o_pix.data == 12'h002)
		else $error("Odd pixel gradient wrong.");

	AST_EVEN_FALLS: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h005)) |=> o_pix.data == 12'h0FD)
		else $error("Even pixel gradient wrong.");

	AST_MIDPOINT_PAIR: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h0FF)) ##1 (i_mode == LCTPG_MODE_FIXED && i_depth == LCTPG_DEPTH_8) |->
		o_pix.data == 12'h080 ##1 o_pix.data == 12'h080)
		else $error("Midpoint pixels are not 128.");

	AST_PERIOD_WRAP: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h1FE)) |=> o_pix.data == 12'h0FF)
		else $error("White pixel missing at period end.");

	AST_TEN_BIT_TOP: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_q == LCTPG_ST_ACTIVE && i_mode == LCTPG_MODE_FIXED && i_depth == LCTPG_DEPTH_10 &&
		pix_cnt_q[8:0] == 9'h001) |=> o_pix.data == 12'h3FF)
		else $error("Ten bit full scale wrong.");

	AST_TWELVE_BIT_TOP: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_q == LCTPG_ST_ACTIVE && i_mode == LCTPG_MODE_FIXED && i_depth == LCTPG_DEPTH_12 &&
		pix_cnt_q[8:0] == 9'h001) |=> o_pix.data == 12'hFFF)
		else $error("Twelve bit full scale wrong.");

	AST_VIDEO_PASS: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_mode == LCTPG_MODE_VIDEO) |=> o_pix == $past(i_video))
		else $error("Normal video not passed through.");

	AST_FIRST_ODD_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h000)) |=> o_pix.valid && o_pix.data == 12'h000)
		else $error("First odd pixel is not black.");

	AST_FIRST_EVEN_TOP: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h001)) |=> o_pix.valid && o_pix.data == 12'h0FF)
		else $error("First even pixel is not white.");

	AST_WRAP_PAIR: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h1FE) ##1 seq_fixed8_at(9'h1FF)) |->
		o_pix.data == 12'h0FF ##1 o_pix.data == 12'h000)
		else $error("White odd next to black even missing at period end.");

	AST_RESTART_PAIR: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed8_at(9'h000) ##1 seq_fixed8_at(9'h001)) |->
		o_pix.data == 12'h000 ##1 o_pix.data == 12'h0FF)
		else $error("Black odd next to white even missing at period start.");

	AST_EIGHT_BIT_RANGE: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_active_in(LCTPG_MODE_FIXED, LCTPG_DEPTH_8)) |=> o_pix.data[11:8] == 4'h0)
		else $error("Eight bit gradient exceeds its range.");

	AST_TEN_BIT_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed_at(LCTPG_DEPTH_10, 9'h000)) |=> o_pix.data == 12'h000)
		else $error("Ten bit zero code wrong.");

	AST_TEN_BIT_RANGE: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_active_in(LCTPG_MODE_FIXED, LCTPG_DEPTH_10)) |=> o_pix.data[11:10] == 2'h0)
		else $error("Ten bit gradient exceeds its range.");

	AST_TWELVE_BIT_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_fixed_at(LCTPG_DEPTH_12, 9'h000)) |=> o_pix.data == 12'h000)
		else $error("Twelve bit zero code wrong.");

	AST_BLACK_LINE: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_q == LCTPG_ST_ACTIVE && i_mode == LCTPG_MODE_BLACK) |=> o_pix.valid && o_pix.data == 12'h000)
		else $error("Black pattern pixel is not zero.");

	AST_GRAY_EIGHT: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_active_in(LCTPG_MODE_GRAY, LCTPG_DEPTH_8)) |=> o_pix.valid && o_pix.data == 12'h07F)
		else $error("Eight bit gray level wrong.");

	AST_GRAY_TEN: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_active_in(LCTPG_MODE_GRAY, LCTPG_DEPTH_10)) |=> o_pix.valid && o_pix.data == 12'h1FF)
		else $error("Ten bit gray level wrong.");

	AST_GRAY_TWELVE: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_active_in(LCTPG_MODE_GRAY, LCTPG_DEPTH_12)) |=> o_pix.valid && o_pix.data == 12'h7FF)
		else $error("Twelve bit gray level wrong.");

	AST_MOVE_STEPS: assert property (@(posedge i_clk) disable iff (i_reset)
		(seq_active_in(LCTPG_MODE_MOVE, LCTPG_DEPTH_8) ##1 seq_active_in(LCTPG_MODE_MOVE, LCTPG_DEPTH_8)) |=>
		o_pix.data == {4'h0, 8'($past(o_pix.data[7:0]) + 8'h01)})
		else $error("Moving gradient does not step up by one.");

	AST_IDLE_BLANK: assert property (@(posedge i_clk) disable iff (i_reset)
		(test_mode && state_q == LCTPG_ST_IDLE) |=> !o_pix.valid && o_pix.data == 12'h000)
		else $error("Pixel emitted outside a line.");

	AST_EDGE_FROM_PIN: assert property (@(posedge i_clk) disable iff (i_reset)
		trig_edge |-> $past(i_line_trigger_input, 2))
		else $error("Trigger edge seen without the pin high.");

	AST_ACTIVE_VALID: assert property (@(posedge i_clk) disable iff (i_reset)
		(test_mode && state_q == LCTPG_ST_ACTIVE) |=> o_pix.valid)
		else $error("Line pixel not marked valid.");

	AST_LINE_LENGTH: assert property (@(posedge i_clk) disable iff (i_reset)
		($past(test_mode, 2) && $past(test_mode) && $fell(o_pix.valid)) |->
		valid_run_q == ({1'b0, LINE_LAST} + 13'h0001))
		else $error("Line did not hold exactly one line of valid pixels.");

	AST_PIX_ADVANCE: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_q == LCTPG_ST_ACTIVE && pix_cnt_q != LINE_LAST) |=>
		(state_q == LCTPG_ST_ACTIVE && pix_cnt_q == $past(pix_cnt_q) + 12'h001))
		else $error("Pixel position did not advance by one.");

	AST_LINE_END: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_q == LCTPG_ST_ACTIVE && pix_cnt_q == LINE_LAST) |=> state_q == LCTPG_ST_IDLE && pix_cnt_q == PIX_FIRST)
		else $error("Line did not end after its last pixel.");

endmodule

//--- tb/lctpg_grabber.sv
// Frame grabber model: raises the line trigger and captures each video line.
// Assumes the generator output is registered on i_clk.
`timescale 1ns/1ps
module lctpg_grabber
	import lctpg_pkg::*;
(
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// Video from the generator.
	input  wire lctpg_pix_t i_pix,
	// Line trigger pin.
	output logic            o_line_trigger_input
);
	logic [11:0] mem [4096];
	int          cnt;
	int          lines;
	int          last_len;
	initial o_line_trigger_input = 1'b0;
	always @(posedge i_clk) begin
		if (i_reset) begin
			cnt <= 0;
			lines <= 0;
		end else if (i_pix.valid === 1'b1) begin
			mem[cnt % 4096] <= i_pix.data;
			cnt <= cnt + 1;
		end else if (cnt != 0) begin
			last_len <= cnt;
			lines <= lines + 1;
			cnt <= 0;
		end
	end
	// Sends one trigger pulse, held four clock cycles, long enough for the pin synchronizer.
	task automatic pulse();
		@(posedge i_clk);
		o_line_trigger_input <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_line_trigger_input <= 1'b0;
	endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the test pattern generator.
// Assumes the grabber model in the same folder.
`timescale 1ns/1ps
module tb_top;
	import lctpg_pkg::*;
	logic         clk;
	logic         rst;
	logic         free_run;
	logic         trig;
	logic [15:0]  period;
	lctpg_mode_t  mode;
	lctpg_depth_t depth;
	lctpg_pix_t   video;
	lctpg_pix_t   pix;
	int           fail_count;
	int           compares;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	lctpg_top i_dut (.i_clk(clk), .i_reset(rst), .i_mode(mode), .i_depth(depth), .i_free_run(free_run),
		.i_line_period(period), .i_line_trigger_input(trig), .i_video(video), .o_pix(pix));
	lctpg_grabber i_grab (.i_clk(clk), .i_reset(rst), .i_pix(pix), .o_line_trigger_input(trig));
	task automatic chk(string n, logic [12:0] s, logic [12:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wait_line();
		int l;
		l = i_grab.lines;
		for (int i = 0; i < 9000 && i_grab.lines == l; i++) @(posedge clk);
		if (i_grab.lines == l) begin
			fail_count++;
			finish_test();
		end
	endtask
	function automatic logic [11:0] grad(int p, lctpg_depth_t d);
		logic [7:0] v;
		v = (p % 512) % 2 ? 8'(255 - (p % 512 - 1) / 2) : 8'((p % 512) / 2);
		return d == LCTPG_DEPTH_10 ? {2'h0, v, v[7:6]} : d == LCTPG_DEPTH_12 ? {v, v[7:4]} : {4'h0, v};
	endfunction
	// Triggered fixed gradient line, checked pixel by pixel.
	task automatic fixed_line(lctpg_depth_t d);
		depth <= d;
		mode <= LCTPG_MODE_FIXED;
		i_grab.pulse();
		wait_line();
		chk("line length", 13'(i_grab.last_len), 13'h1000);
		for (int p = 0; p < 4096; p++) chk("gradient", i_grab.mem[p], grad(p, d));
		chk("full scale", i_grab.mem[1], d == LCTPG_DEPTH_10 ? 12'h3FF : d == LCTPG_DEPTH_12 ? 12'hFFF : 12'h0FF);
		if (d == LCTPG_DEPTH_8) begin
			chk("midpoint", i_grab.mem[255], 12'h080);
			chk("midpoint next", i_grab.mem[256], 12'h080);
			chk("white odd", i_grab.mem[510], 12'h0FF);
			chk("black even", i_grab.mem[511], 12'h000);
			chk("black odd", i_grab.mem[512], 12'h000);
			chk("white even", i_grab.mem[513], 12'h0FF);
		end
	endtask
	// No trigger toggle, so no line may appear.
	task automatic no_trigger();
		int l;
		l = i_grab.lines;
		repeat (5000) @(posedge clk);
		chk("idle lines", 13'(i_grab.lines), 13'(l));
	endtask
	// Free run emits lines on the internal period.
	task automatic free_lines();
		free_run <= 1'b1;
		wait_line();
		wait_line();
		chk("free run length", 13'(i_grab.last_len), 13'h1000);
		chk("free run pixel", i_grab.mem[511], 12'h000);
		free_run <= 1'b0;
		repeat (4300) @(posedge clk);
	endtask
	// Flat patterns at the given depth.
	task automatic flat(lctpg_mode_t m, lctpg_depth_t d, logic [11:0] e);
		mode <= m;
		depth <= d;
		i_grab.pulse();
		wait_line();
		chk("flat first", i_grab.mem[0], e);
		chk("flat last", i_grab.mem[4095], e);
	endtask
	// Moving gradient steps up along the line and shifts by one on each line.
	task automatic move_lines();
		mode <= LCTPG_MODE_MOVE;
		depth <= LCTPG_DEPTH_8;
		for (int k = 0; k < 2; k++) begin
			i_grab.pulse();
			wait_line();
			chk("move first", i_grab.mem[0], 12'(k));
			chk("move wrap", i_grab.mem[255], 12'(k + 255) & 12'h0FF);
			chk("move repeat", i_grab.mem[256], 12'(k));
		end
	endtask
	// Video mode passes sensor data through.
	task automatic video_pass();
		mode <= LCTPG_MODE_VIDEO;
		video <= {1'b1, 12'hABC};
		repeat (3) @(posedge clk);
		#1;
		chk("video", pix, {1'b1, 12'hABC});
		@(posedge clk);
		video <= {1'b0, 12'h123};
		#1;
		chk("video held", pix, {1'b1, 12'hABC});
		@(posedge clk);
		#1;
		chk("video next", pix, {1'b0, 12'h123});
	endtask
	initial begin
		rst = 1'b1;
		mode = LCTPG_MODE_VIDEO;
		depth = LCTPG_DEPTH_8;
		free_run = 1'b0;
		period = 16'h1068;
		video = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		fixed_line(LCTPG_DEPTH_8);
		fixed_line(LCTPG_DEPTH_8);
		fixed_line(LCTPG_DEPTH_10);
		fixed_line(LCTPG_DEPTH_12);
		no_trigger();
		free_lines();
		flat(LCTPG_MODE_BLACK, LCTPG_DEPTH_12, 12'h000);
		flat(LCTPG_MODE_GRAY, LCTPG_DEPTH_8, 12'h07F);
		flat(LCTPG_MODE_GRAY, LCTPG_DEPTH_10, 12'h1FF);
		flat(LCTPG_MODE_GRAY, LCTPG_DEPTH_12, 12'h7FF);
		move_lines();
		video_pass();
		finish_test();
	end
endmodule
